// ==== hw/wdrc_pkg.sv ====
package wdrc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] ADDR_DOG_CTRL    = 8'h21;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h20;

    // Control and status field positions
    localparam int BIT_IRQ_FLAG = 7;
    localparam int BIT_IRQ_EN   = 6;
    localparam int BIT_SEL_HI   = 5;
    localparam int BIT_UNLOCK   = 4;
    localparam int BIT_ENABLE   = 3;
    localparam int BIT_SEL_LO   = 0;

    // Reset-cause field positions
    localparam int RC_DOG      = 3;
    localparam int RC_BROWNOUT = 2;
    localparam int RC_PIN      = 1;
    localparam int RC_POWERON  = 0;
    localparam int RC_COUNT    = 4;

    // Reset values
    localparam logic [3:0] SEL_RESET      = 4'h0;
    localparam logic [3:0] RC_AT_POWERON  = 4'h1;
    localparam logic [3:0] RC_UPPER_READ  = 4'h0;
    localparam logic [7:0] RD_IDLE        = 8'h00;

    // Unlock window length in clock cycles
    localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;

    // Timeout select limits
    localparam logic [3:0] SEL_MAX_VALID = 4'h9;
    localparam logic [3:0] SEL_FALLBACK  = 4'h9;

    // Oscillator ticks of the shortest period, and counter width
    localparam int DOG_BASE_TICKS = 2048;
    localparam int DOG_CNT_W      = 21;

    // Fuse level that selects safety level two
    localparam logic SAFETY_LEVEL2_FUSE = 1'b1;

    // Change window states
    typedef enum logic [1:0] {
        WIN_LOCKED = 2'b01,
        WIN_OPEN   = 2'b10
    } wdrc_win_t;

endpackage

// ==== hw/wdrc_dog_counter.sv ====
`timescale 1ns/1ns
// Time-out counter stepped by oscillator ticks
module wdrc_dog_counter import wdrc_pkg::*; #(
    parameter int BASE_TICKS = DOG_BASE_TICKS
) (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // Counter control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic       slowTick,
    input  wire logic [3:0] timeoutSelect,
    // Expiry pulse
    output logic            expire
);

    logic [3:0]           selEff;   // Select after reserved fallback
    logic [DOG_CNT_W-1:0] lastCnt;  // Final count of the period
    logic [DOG_CNT_W-1:0] cnt_q;    // Ticks seen so far
    logic                 expire_q; // Registered expiry

    // Reserved codes fall back to the longest valid period
    always_comb begin
        if (timeoutSelect > SEL_MAX_VALID) begin
            selEff = SEL_FALLBACK;
        end else begin
            selEff = timeoutSelect;
        end
        lastCnt = DOG_CNT_W'((BASE_TICKS << selEff) - 1);
    end

    // Count ticks; restart when stopped, kicked or reset
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst || restart || !run) begin
                cnt_q <= '0;
            end else if (slowTick) begin
                // Wrap at the end of the period
                if (cnt_q >= lastCnt) begin
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    // One-cycle expiry pulse
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                expire_q <= 1'b0;
            end else begin
                expire_q <= run && !restart && slowTick && (cnt_q >= lastCnt);
            end
        end
    end

    assign expire = expire_q;

endmodule

// ==== hw/wdrc_watchdog.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/1ns
// Watchdog with protected configuration and reset-cause flags
module wdrc_watchdog import wdrc_pkg::*; #(
    parameter int TIMEOUT_BASE_TICKS = DOG_BASE_TICKS
) (
    // Clock, reset and freeze
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    // Fuse and oscillator
    input  wire logic       safetyLevelFuse,
    input  wire logic       slowTick,
    // Core side
    input  wire logic       dogRestart,
    input  wire logic       globalIrqEnable,
    input  wire logic       irqVectorAck,
    // Reset detector events
    input  wire logic       powerOnEvt,
    input  wire logic       brownoutEvt,
    input  wire logic       pinResetEvt,
    // Results
    output logic            timeoutIrqReq,
    output logic            dogResetPulse
);

    // Decoded accesses
    logic       wrCtrl;        // Write to the control register
    logic       wrCause;       // Write to the reset-cause register
    logic       rdCtrl;        // Read of the control register
    logic       rdCause;       // Read of the reset-cause register

    // Fields of the written byte
    logic       wrUnlock;      // Unlock bit written
    logic       wrEnable;      // Enable bit written
    logic [3:0] wrSelect;      // Timeout select written

    // Safety level and window
    logic       levelTwo;      // Fuse selects level two
    wdrc_win_t  win_q;         // Change window state
    wdrc_win_t  win_d;         // Next window state
    logic [2:0] winCnt_q;      // Cycles left in the window
    logic [2:0] winCnt_d;      // Next window count
    logic       winOpen;       // Window open this cycle
    logic       openingWrite;  // Write that opens the window
    logic       changeWrite;   // Second write inside the window

    // Configuration
    logic       enable_q;      // Stored enable bit
    logic       enableEff;     // Enable as seen by the logic
    logic [3:0] select_q;      // Timeout select
    logic       irqEn_q;       // Timeout interrupt enable
    logic       irqFlag_q;     // Timeout interrupt flag

    // Time-out handling
    logic       running;       // Counter runs
    logic       expire;        // Period ended this cycle
    logic       toIrq;         // Time-out goes to interrupt
    logic       toReset;       // Time-out goes to reset
    logic       dogReset_q;    // Registered reset pulse

    // Reset-cause flags
    logic [RC_COUNT-1:0] cause_q;   // Sticky cause flags
    logic [RC_COUNT-1:0] causeSet;  // Hardware set per flag
    logic [7:0]          rdData_q;  // Registered read data

    // Address decode
    // Both registers share one strobe pair; an address that matches
    // neither register leaves every flop alone and reads back zero.
    // The bus master never issues both strobes in one cycle, so the
    // write and read decodes never fight over the same register.
    always_comb begin
        wrCtrl  = regWrEn && (regAddr == ADDR_DOG_CTRL);
        wrCause = regWrEn && (regAddr == ADDR_RESET_CAUSE);
        rdCtrl  = regRdEn && (regAddr == ADDR_DOG_CTRL);
        rdCause = regRdEn && (regAddr == ADDR_RESET_CAUSE);
    end

    // Fields of the written control byte
    // The select code is split around the unlock and enable bits,
    // so the top select bit is gathered from bit five of the byte.
    always_comb begin
        wrUnlock = regWrData[BIT_UNLOCK];
        wrEnable = regWrData[BIT_ENABLE];
        wrSelect = {regWrData[BIT_SEL_HI], regWrData[BIT_SEL_LO+2:BIT_SEL_LO]};
    end

    // Fuse level is read live; it is a static strap
    assign levelTwo = (safetyLevelFuse == SAFETY_LEVEL2_FUSE);

    // Window classification of control writes
    // An opening write needs enable written as one even when the dog
    // already runs; this keeps a stray unlock write from ever being
    // able to stop the dog by itself.
    // A change write is any control write with unlock clear while the
    // window stands open; it closes the window whatever it carries.
    always_comb begin
        winOpen      = (win_q == WIN_OPEN);
        // Unlock and enable both one in one write
        openingWrite = wrCtrl && wrUnlock && wrEnable;
        // Unlock cleared while the window is open
        changeWrite  = wrCtrl && !wrUnlock && winOpen;
    end

    // Next state of the change window
    // The window counts the four cycles after the opening write; a
    // change write taken on the fourth of them is still accepted.
    // Reading the unlock bit shows whether the window is open.
    always_comb begin
        win_d    = win_q;
        winCnt_d = winCnt_q;
        unique case (win_q)
            WIN_LOCKED: begin
                // Open for four cycles after the unlock write
                if (openingWrite) begin
                    win_d    = WIN_OPEN;
                    winCnt_d = UNLOCK_WINDOW_CYCLES;
                end
            end
            WIN_OPEN: begin
                if (openingWrite) begin
                    // A new unlock write restarts the window
                    winCnt_d = UNLOCK_WINDOW_CYCLES;
                end else if (changeWrite || winCnt_q <= 3'h1) begin
                    // Used up or timed out
                    win_d    = WIN_LOCKED;
                    winCnt_d = 3'h0;
                end else begin
                    winCnt_d = winCnt_q - 3'h1;
                end
            end
            default: begin
                win_d    = WIN_LOCKED;
                winCnt_d = 3'h0;
            end
        endcase
    end

    // Window registers
    // A chip reset always leaves the window locked.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                win_q    <= WIN_LOCKED;
                winCnt_q <= 3'h0;
            end else begin
                win_q    <= win_d;
                winCnt_q <= winCnt_d;
            end
        end
    end

    // Effective enable: level two always on; level one held by dog flag
    // Holding enable while the dog flag is set makes a failing program
    // reset again and again instead of running with the dog stopped.
    always_comb begin
        if (levelTwo) begin
            enableEff = 1'b1;
        end else begin
            enableEff = enable_q || cause_q[RC_DOG];
        end
    end

    // Stored enable bit
    // At level two the stored bit is never used, so writes skip it.
    // Setting is free at level one; clearing needs the window and a
    // cleared dog flag, otherwise the write of zero is dropped.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                enable_q <= 1'b0;
            end else if (wrCtrl && !levelTwo) begin
                if (wrEnable) begin
                    // Setting needs no unlock
                    enable_q <= 1'b1;
                end else if (changeWrite && !cause_q[RC_DOG]) begin
                    // Clearing only in the window, after the dog flag
                    enable_q <= 1'b0;
                end
                // Zero outside the window is dropped
            end
        end
    end

    // Timeout select
    // Reserved codes are stored as written; the counter maps them to a
    // valid period, so a read shows what software wrote.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                select_q <= SEL_RESET;
            end else if (wrCtrl) begin
                if (!levelTwo) begin
                    // Level one changes the period freely
                    select_q <= wrSelect;
                end else if (changeWrite) begin
                    // Level two only in the window; enable ignored
                    select_q <= wrSelect;
                end
            end
        end
    end

    // Time-out action from enable and interrupt enable
    // With both bits set the first time-out interrupts and the next
    // one resets, unless software sets the interrupt enable again.
    always_comb begin
        running = enableEff || irqEn_q;
        toIrq   = expire && irqEn_q;
        toReset = expire && !irqEn_q && enableEff;
    end

    // Timeout interrupt enable
    // The hardware clear only applies when enable is set, so a pure
    // interrupt mode keeps interrupting on every period.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                irqEn_q <= 1'b0;
            end else if (wrCtrl) begin
                // A software write wins over the hardware clear
                irqEn_q <= regWrData[BIT_IRQ_EN];
            end else if (toIrq && enableEff) begin
                // Next time-out becomes a reset
                irqEn_q <= 1'b0;
            end
        end
    end

    // Timeout interrupt flag; a new time-out wins over any clear
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                irqFlag_q <= 1'b0;
            end else if (toIrq) begin
                irqFlag_q <= 1'b1;
            end else if (irqVectorAck) begin
                irqFlag_q <= 1'b0;
            end else if (wrCtrl && regWrData[BIT_IRQ_FLAG]) begin
                irqFlag_q <= 1'b0;
            end
        end
    end

    // Interrupt request needs both enables
    // The request is combinational so the core sees a change of the
    // global enable in the same cycle.
    assign timeoutIrqReq = irqFlag_q && irqEn_q && globalIrqEnable;

    // Time-out counter
    // The counter is stepped by oscillator ticks, not by the system
    // clock, so the period does not depend on the core clock rate.
    wdrc_dog_counter #(
        .BASE_TICKS    (TIMEOUT_BASE_TICKS)
    ) u_counter (
        .clk           (clk),
        .srst          (srst),
        .clkEn         (clkEn),
        .run           (running),
        .restart       (dogRestart),
        .slowTick      (slowTick),
        .timeoutSelect (select_q),
        .expire        (expire)
    );

    // One-cycle system reset request
    // Registered so that the reset tree sees a clean single pulse.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                dogReset_q <= 1'b0;
            end else begin
                dogReset_q <= toReset;
            end
        end
    end

    assign dogResetPulse = dogReset_q;

    // Hardware set events per cause flag
    // The dog flag is set from the registered reset pulse, one cycle
    // after the request leaves the block.
    always_comb begin
        causeSet              = '0;
        causeSet[RC_DOG]      = dogReset_q;
        causeSet[RC_BROWNOUT] = brownoutEvt;
        causeSet[RC_PIN]      = pinResetEvt;
        causeSet[RC_POWERON]  = powerOnEvt;
    end

    // Cause flags survive the chip reset; power-on restarts them
    // They carry no reset branch on purpose: the flags must outlive
    // the very resets that they record.
    generate
        for (genvar i = 0; i < RC_COUNT; i++) begin : g_cause
            always_ff @(posedge clk) begin
                if (clkEn) begin
                    if (causeSet[i]) begin
                        // A set wins over a clear in the same cycle
                        cause_q[i] <= 1'b1;
                    end else if (powerOnEvt) begin
                        // Power-on clears the other flags
                        cause_q[i] <= RC_AT_POWERON[i];
                    end else if (wrCause && !regWrData[i]) begin
                        // Zero clears; one leaves the flag alone
                        cause_q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Read data, valid only in the cycle after the read strobe
    // Returning zero in idle cycles keeps a shared read bus quiet.
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (srst) begin
                rdData_q <= RD_IDLE;
            end else if (rdCtrl) begin
                rdData_q <= {irqFlag_q, irqEn_q, select_q[3], winOpen,
                             enableEff, select_q[2:0]};
            end else if (rdCause) begin
                // Upper nibble is always zero
                rdData_q <= {RC_UPPER_READ, cause_q};
            end else begin
                // Unmapped reads and idle cycles return zero
                rdData_q <= RD_IDLE;
            end
        end
    end

    assign regRdData = rdData_q;

endmodule

// ==== verif/wdrc_watchdog_assertions.sv ====
`timescale 1ns/1ns
// Port-level checks of the watchdog top
module wdrc_watchdog_checker import wdrc_pkg::*; #(
    parameter int TIMEOUT_BASE_TICKS = DOG_BASE_TICKS
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regRdEn,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    input wire logic [7:0] regRdData,
    // Strap and core side
    input wire logic       safetyLevelFuse,
    input wire logic       dogRestart,
    input wire logic       globalIrqEnable,
    input wire logic       irqVectorAck,
    // Results
    input wire logic       timeoutIrqReq,
    input wire logic       dogResetPulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Read strobes of each register
    sequence rdCtrl;
        regRdEn && (regAddr == ADDR_DOG_CTRL);
    endsequence
    sequence rdCause;
        regRdEn && (regAddr == ADDR_RESET_CAUSE);
    endsequence

    // Read data idle outside the answer cycle
    a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == RD_IDLE) else $error("read data not idle");
    a_cause_upper_zero: assert property (rdCause |=> regRdData[7:4] == RC_UPPER_READ)
        else $error("upper cause bits not zero");
    a_level2_enable_one: assert property (rdCtrl ##0 safetyLevelFuse |=> regRdData[BIT_ENABLE])
        else $error("enable not read as one");
    a_irq_needs_global: assert property (timeoutIrqReq |-> globalIrqEnable)
        else $error("request without global enable");
    a_reset_pulse_short: assert property (dogResetPulse |=> !dogResetPulse)
        else $error("reset pulse too long");
    a_restart_stays_quiet: assert property (dogRestart |-> ##2 !dogResetPulse [*4])
        else $error("reset right after restart");
    a_vector_clears_flag: assert property (irqVectorAck |=> !timeoutIrqReq)
        else $error("vector did not clear request");
    a_write_one_clears: assert property (regWrEn && regAddr == ADDR_DOG_CTRL && regWrData[BIT_IRQ_FLAG]
        |=> !timeoutIrqReq) else $error("write one did not clear request");
endmodule

bind wdrc_watchdog wdrc_watchdog_checker #(.TIMEOUT_BASE_TICKS(TIMEOUT_BASE_TICKS)) chk_u (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regRdEn(regRdEn), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdData(regRdData), .safetyLevelFuse(safetyLevelFuse),
    .dogRestart(dogRestart), .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck),
    .timeoutIrqReq(timeoutIrqReq), .dogResetPulse(dogResetPulse));

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
// Register-level test of the watchdog
module testbench import wdrc_pkg::*;;
    localparam int BASE = 4;              // Shortened period of select 0
    logic clk = 0, srst = 1, clkEn = 1;   // Clock, reset, freeze
    logic [7:0] regAddr = 0, regWrData = 0, rd;
    logic regWrEn = 0, regRdEn = 0, fuse = 0, slowTick = 0;
    logic glb = 0;
    logic [4:0] ev = 5'h00;               // Pulsed core and detector inputs
    localparam int EV_POR = 0, EV_BOR = 1, EV_PIN = 2, EV_ACK = 3, EV_KICK = 4;
    wire por = ev[EV_POR], bor = ev[EV_BOR], pin = ev[EV_PIN];
    wire ack = ev[EV_ACK], dogRestart = ev[EV_KICK];
    logic timeoutIrqReq, dogResetPulse;
    int num_errors = 0, checks_done = 0, pulses = 0, cyc = 0, n;

    wdrc_watchdog #(.TIMEOUT_BASE_TICKS(BASE)) dut_u (.clk(clk), .srst(srst), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(rd), .safetyLevelFuse(fuse), .slowTick(slowTick), .dogRestart(dogRestart),
        .globalIrqEnable(glb), .irqVectorAck(ack), .powerOnEvt(por), .brownoutEvt(bor),
        .pinResetEvt(pin), .timeoutIrqReq(timeoutIrqReq), .dogResetPulse(dogResetPulse));

    // 50 ns clock
    always #25 clk = ~clk;

    // Count reset pulses and cut a hang short
    always @(posedge clk) begin
        pulses <= pulses + int'(dogResetPulse === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end

    // Verdict
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Comparisons of bytes and bits
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp8({7'h00, g}, {7'h00, e});
    endtask

    // Bus cycles
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin regWrEn <= 1; regAddr <= a; regWrData <= d; end
        @(posedge clk) regWrEn <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) begin regRdEn <= 1; regAddr <= a; end
        @(posedge clk) regRdEn <= 0;
        #1 cmp8(rd, e);
    endtask
    // One-cycle pulse on a core or detector input
    task automatic pulse(input int w);
        @(posedge clk) ev[w] <= 1'b1;
        @(posedge clk) ev[w] <= 1'b0;
    endtask
    // Run oscillator ticks until a time-out shows, n is the cycle count
    task automatic waitEv();
        n = 0;
        @(posedge clk) slowTick <= 1;
        do begin
            @(posedge clk);
            #1 n++;
        end while (dogResetPulse !== 1'b1 && timeoutIrqReq !== 1'b1 && n < 100);
        @(posedge clk) slowTick <= 0;
        // Let the pulse counter settle before it is compared
        #1;
    endtask

    initial begin
        idle(12);
        @(posedge clk) srst <= 0;
        pulse(EV_POR);
        // Reset causes
        rdc(ADDR_RESET_CAUSE, 8'h01);
        rdc(ADDR_DOG_CTRL, 8'h00);
        rdc(8'h22, 8'h00);
        pulse(EV_BOR);
        pulse(EV_PIN);
        rdc(ADDR_RESET_CAUSE, 8'h07);
        wr(ADDR_RESET_CAUSE, 8'hFF);
        rdc(ADDR_RESET_CAUSE, 8'h07);
        @(posedge clk) srst <= 1;
        idle(2);
        @(posedge clk) srst <= 0;
        rdc(ADDR_RESET_CAUSE, 8'h07);
        wr(ADDR_RESET_CAUSE, 8'h00);
        rdc(ADDR_RESET_CAUSE, 8'h00);
        // Level one enable and timed disable
        wr(ADDR_DOG_CTRL, 8'h08);
        rdc(ADDR_DOG_CTRL, 8'h08);
        wr(ADDR_DOG_CTRL, 8'h00);
        rdc(ADDR_DOG_CTRL, 8'h08);
        wr(ADDR_DOG_CTRL, 8'h18);
        idle(2);
        wr(ADDR_DOG_CTRL, 8'h01);
        rdc(ADDR_DOG_CTRL, 8'h01);
        wr(ADDR_DOG_CTRL, 8'h08);
        wr(ADDR_DOG_CTRL, 8'h18);
        idle(3);
        wr(ADDR_DOG_CTRL, 8'h00);
        rdc(ADDR_DOG_CTRL, 8'h08);
        // Time-out in reset mode
        waitEv();
        cmp1(n >= BASE && n <= BASE + 2, 1'b1);
        cmp8(8'(pulses), 8'h01);
        rdc(ADDR_RESET_CAUSE, 8'h08);
        wr(ADDR_DOG_CTRL, 8'h18);
        wr(ADDR_DOG_CTRL, 8'h00);
        idle(3);
        rdc(ADDR_DOG_CTRL, 8'h08);
        // Restarts keep the dog quiet
        slowTick <= 1;
        repeat (10) begin
            pulse(EV_KICK);
            idle(1);
        end
        slowTick <= 0;
        cmp8(8'(pulses), 8'h01);
        // Interrupt-only mode
        wr(ADDR_RESET_CAUSE, 8'h00);
        wr(ADDR_DOG_CTRL, 8'h18);
        wr(ADDR_DOG_CTRL, 8'h40);
        glb <= 1;
        waitEv();
        cmp1(timeoutIrqReq, 1'b1);
        cmp8(8'(pulses), 8'h01);
        @(posedge clk) glb <= 0;
        #1 cmp1(timeoutIrqReq, 1'b0);
        @(posedge clk) glb <= 1;
        #1 cmp1(timeoutIrqReq, 1'b1);
        pulse(EV_ACK);
        #1 cmp1(timeoutIrqReq, 1'b0);
        glb <= 0;
        // Interrupt first, then reset
        wr(ADDR_DOG_CTRL, 8'h48);
        waitEv();
        cmp8(8'(pulses), 8'h02);
        rdc(ADDR_DOG_CTRL, 8'h88);
        wr(ADDR_DOG_CTRL, 8'h88);
        rdc(ADDR_DOG_CTRL, 8'h08);
        // Safety level two
        fuse <= 1;
        wr(ADDR_DOG_CTRL, 8'h03);
        rdc(ADDR_DOG_CTRL, 8'h08);
        wr(ADDR_DOG_CTRL, 8'h18);
        wr(ADDR_DOG_CTRL, 8'h05);
        idle(3);
        rdc(ADDR_DOG_CTRL, 8'h0D);
        // Frozen clock enable drops a full change sequence
        @(posedge clk) clkEn <= 0;
        wr(ADDR_DOG_CTRL, 8'h18);
        wr(ADDR_DOG_CTRL, 8'h02);
        @(posedge clk) clkEn <= 1;
        rdc(ADDR_DOG_CTRL, 8'h0D);
        end_sim();
    end
endmodule
